// ==== hw/chan_map_regs.svh ====
// constants for the coordinate to channel address mapping block
// assumes: included by the package and the design modules by bare name
//
// How it works
// - channel address is twelve bits, each with its own source select
// - ten-bit x and y coordinate inputs
// - unselected address bits are forced zero
// - used bits fill lowest addresses, rest zero
// - at most twelve coordinate bits, y-only allowed
// - partial coordinate uses its top bits
// - each axis maps ascending onto contiguous run
// - default: y7..0 low, x7..4 high
// - x-only: x7..1 to a6..0, rest zero
// - square pixels: y7..2 low, x7..2 high
`ifndef CHAN_MAP_REGS_SVH
`define CHAN_MAP_REGS_SVH

// ************************************************************
// widths
// ************************************************************
`define ADDR_W        12
`define COORD_W       10
`define SEL_IDX_W     4

// ************************************************************
// per-bit source codes: field [5:4] kind, [3:0] coordinate bit index
// ************************************************************
`define SRC_KIND_ZERO 2'h0
`define SRC_KIND_X    2'h1
`define SRC_KIND_Y    2'h2
`define SRC_CODE_W    6
`define SRC_KIND_LSB  4

// ************************************************************
// preset mapping selections
// ************************************************************
`define PRESET_W          2
`define PRESET_DEFAULT    2'h0
`define PRESET_X_ONLY     2'h1
`define PRESET_SQUARE     2'h2
`define PRESET_CUSTOM     2'h3

// preset field widths and positions
`define DEF_Y_LSB     4'h0
`define DEF_Y_CNT     4'h8
`define DEF_X_LSB     4'h4
`define DEF_X_CNT     4'h4
`define XO_X_LSB      4'h1
`define XO_X_CNT      4'h7
`define SQ_Y_LSB      4'h2
`define SQ_Y_CNT      4'h6
`define SQ_X_LSB      4'h2
`define SQ_X_CNT      4'h6
`define NONE_CNT      4'h0

`endif

// ==== hw/chan_map_pkg.sv ====
// types for the coordinate to channel address mapping block
// assumes: chan_map_regs.svh is on the include path
`include "chan_map_regs.svh"

package chan_map_pkg;

    typedef logic [`ADDR_W-1:0]     chan_addr_t;
    typedef logic [`COORD_W-1:0]    coord_t;
    typedef logic [`SEL_IDX_W-1:0]  bit_idx_t;
    typedef logic [`PRESET_W-1:0]   preset_t;

    // which axis feeds the low address bits
    typedef enum logic {
        low_y = 1'b0,
        low_x = 1'b1
    } low_axis_e;

endpackage

// ==== hw/chan_addr_mux.sv ====
// one address bit source selector per channel address bit
// assumes: select codes are held stable by the caller
`timescale 1ns/100ps
`default_nettype none
`include "chan_map_regs.svh"

module chan_addr_mux
    import chan_map_pkg::*;
(
    input  wire logic [`COORD_W-1:0]              x_coord,
    input  wire logic [`COORD_W-1:0]              y_coord,
    input  wire logic [`ADDR_W*`SRC_CODE_W-1:0]   src_codes,
    output logic      [`ADDR_W-1:0]               addr
);

    // ************************************************************
    // per-bit selection
    // ************************************************************

    // pick one source for a single address bit; bad index reads zero
    function automatic logic pick_bit(input logic [`SRC_CODE_W-1:0] code,
                                      input coord_t xc,
                                      input coord_t yc);
        logic [1:0] kind;
        bit_idx_t   idx;
        logic       val;
        kind = code[`SRC_CODE_W-1:`SRC_KIND_LSB];
        idx  = code[`SRC_KIND_LSB-1:0];
        val  = 1'b0;
        if (idx < bit_idx_t'(`COORD_W)) begin
            if (kind == `SRC_KIND_X) begin
                val = xc[idx];
            end else if (kind == `SRC_KIND_Y) begin
                val = yc[idx];
            end
        end
        return val; // zero kind never floats
    endfunction

    genvar g;
    generate
        for (g = 0; g < `ADDR_W; g = g + 1) begin : g_bit
            // each address bit has its own selector
            assign addr[g] = pick_bit(src_codes[g*`SRC_CODE_W +: `SRC_CODE_W], x_coord, y_coord);
        end
    endgenerate

endmodule // chan_addr_mux

`default_nettype wire

// ==== hw/chan_map.sv ====
// coordinate to histogram channel address mapping, registered output
// assumes: coordinates synchronous to clock; mapping straps held stable
`timescale 1ns/100ps
`default_nettype none
`include "chan_map_regs.svh"

module chan_map
    import chan_map_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    resetn,
    input  wire logic [`COORD_W-1:0]     x_coord,
    input  wire logic [`COORD_W-1:0]     y_coord,
    input  wire logic                    coord_valid,
    input  wire logic [`PRESET_W-1:0]    preset_sel,
    input  wire logic                    custom_low_x,
    input  wire logic [`SEL_IDX_W-1:0]   custom_x_cnt,
    input  wire logic [`SEL_IDX_W-1:0]   custom_y_cnt,
    input  wire logic [`SEL_IDX_W-1:0]   x_res_msb,
    input  wire logic [`SEL_IDX_W-1:0]   y_res_msb,
    input  wire logic                    y_only_source,
    output logic      [`ADDR_W-1:0]      chan_addr,
    output logic                         chan_valid,
    output logic                         map_error
);

    // ************************************************************
    // reset release
    // ************************************************************

    logic rst_meta;
    logic rst_sync_n;

    // two-stage release keeps deassertion clean to this clock
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ************************************************************
    // mapping capture
    // ************************************************************

    // mapping is latched once after reset release and never moves
    // during accumulation; change needs a reset
    logic      cfg_taken;
    preset_t   cfg_preset;
    logic      cfg_low_x;
    bit_idx_t  cfg_x_cnt;
    bit_idx_t  cfg_y_cnt;
    bit_idx_t  cfg_x_msb;
    bit_idx_t  cfg_y_msb;
    logic      cfg_y_only;
    logic      next_cfg_taken;
    preset_t   next_cfg_preset;
    logic      next_cfg_low_x;
    bit_idx_t  next_cfg_x_cnt;
    bit_idx_t  next_cfg_y_cnt;
    bit_idx_t  next_cfg_x_msb;
    bit_idx_t  next_cfg_y_msb;
    logic      next_cfg_y_only;

    // take straps on first cycle after release
    always_comb begin
        next_cfg_taken  = cfg_taken;
        next_cfg_preset = cfg_preset;
        next_cfg_low_x  = cfg_low_x;
        next_cfg_x_cnt  = cfg_x_cnt;
        next_cfg_y_cnt  = cfg_y_cnt;
        next_cfg_x_msb  = cfg_x_msb;
        next_cfg_y_msb  = cfg_y_msb;
        next_cfg_y_only = cfg_y_only;
        if (!cfg_taken) begin
            next_cfg_taken  = 1'b1;
            next_cfg_preset = preset_sel;
            next_cfg_low_x  = custom_low_x;
            next_cfg_x_cnt  = custom_x_cnt;
            next_cfg_y_cnt  = custom_y_cnt;
            next_cfg_x_msb  = x_res_msb;
            next_cfg_y_msb  = y_res_msb;
            next_cfg_y_only = y_only_source;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_taken  <= 1'b0;
            cfg_preset <= `PRESET_DEFAULT;
            cfg_low_x  <= 1'b0;
            cfg_x_cnt  <= `NONE_CNT;
            cfg_y_cnt  <= `NONE_CNT;
            cfg_x_msb  <= `NONE_CNT;
            cfg_y_msb  <= `NONE_CNT;
            cfg_y_only <= 1'b0;
        end else begin
            cfg_taken  <= next_cfg_taken;
            cfg_preset <= next_cfg_preset;
            cfg_low_x  <= next_cfg_low_x;
            cfg_x_cnt  <= next_cfg_x_cnt;
            cfg_y_cnt  <= next_cfg_y_cnt;
            cfg_x_msb  <= next_cfg_x_msb;
            cfg_y_msb  <= next_cfg_y_msb;
            cfg_y_only <= next_cfg_y_only;
        end
    end

    // ************************************************************
    // source code table
    // ************************************************************

    logic [`ADDR_W*`SRC_CODE_W-1:0] src_codes;
    bit_idx_t                       x_lsb;
    bit_idx_t                       y_lsb;
    bit_idx_t                       x_cnt;
    bit_idx_t                       y_cnt;
    low_axis_e                      low_axis;
    logic                           cfg_bad;

    // derive per-axis slice: count bits ending at the axis top bit
    always_comb begin
        low_axis = low_y;
        x_cnt    = `NONE_CNT;
        y_cnt    = `NONE_CNT;
        x_lsb    = `NONE_CNT;
        y_lsb    = `NONE_CNT;
        case (cfg_preset)
            `PRESET_DEFAULT: begin
                y_lsb = `DEF_Y_LSB;
                y_cnt = `DEF_Y_CNT;
                x_lsb = `DEF_X_LSB;
                x_cnt = `DEF_X_CNT;
            end
            `PRESET_X_ONLY: begin
                low_axis = low_x;
                x_lsb    = `XO_X_LSB;
                x_cnt    = `XO_X_CNT;
            end
            `PRESET_SQUARE: begin
                y_lsb = `SQ_Y_LSB;
                y_cnt = `SQ_Y_CNT;
                x_lsb = `SQ_X_LSB;
                x_cnt = `SQ_X_CNT;
            end
            default: begin
                // custom slices take the top bits of each axis
                low_axis = low_axis_e'(cfg_low_x);
                x_cnt    = cfg_x_cnt;
                y_cnt    = cfg_y_cnt;
                x_lsb    = bit_idx_t'(cfg_x_msb + 4'h1 - cfg_x_cnt);
                y_lsb    = bit_idx_t'(cfg_y_msb + 4'h1 - cfg_y_cnt);
            end
        endcase
        // too many bits, x with y-only source, or custom slice running below bit 0
        cfg_bad = ({1'b0, x_cnt} + {1'b0, y_cnt} > 5'(`ADDR_W))
                || (cfg_y_only && (x_cnt != `NONE_CNT))
                || ({1'b0, x_cnt} > {1'b0, cfg_x_msb} + 5'h1 && cfg_preset == `PRESET_CUSTOM)
                || ({1'b0, y_cnt} > {1'b0, cfg_y_msb} + 5'h1 && cfg_preset == `PRESET_CUSTOM);
    end

    // build codes: low axis from bit 0 up, other axis right after it
    always_comb begin
        logic [4:0] pos;
        logic [4:0] lo_cnt;
        pos       = 5'h00;
        src_codes = '0;
        lo_cnt    = (low_axis == low_x) ? {1'b0, x_cnt} : {1'b0, y_cnt};
        for (int i = 0; i < `ADDR_W; i++) begin
            pos = 5'(i);
            if (cfg_bad) begin
                src_codes[i*`SRC_CODE_W +: `SRC_CODE_W] = {`SRC_KIND_ZERO, 4'h0};
            end else if (pos < lo_cnt) begin
                // ascending order within the run
                src_codes[i*`SRC_CODE_W +: `SRC_CODE_W] = (low_axis == low_x) ?
                    {`SRC_KIND_X, bit_idx_t'(x_lsb + pos[3:0])} :
                    {`SRC_KIND_Y, bit_idx_t'(y_lsb + pos[3:0])};
            end else if (pos < lo_cnt + ((low_axis == low_x) ? {1'b0, y_cnt} : {1'b0, x_cnt})) begin
                src_codes[i*`SRC_CODE_W +: `SRC_CODE_W] = (low_axis == low_x) ?
                    {`SRC_KIND_Y, bit_idx_t'(y_lsb + pos[3:0] - lo_cnt[3:0])} :
                    {`SRC_KIND_X, bit_idx_t'(x_lsb + pos[3:0] - lo_cnt[3:0])};
            end else begin
                // high bits unused stay grounded
                src_codes[i*`SRC_CODE_W +: `SRC_CODE_W] = {`SRC_KIND_ZERO, 4'h0};
            end
        end
    end

    // ************************************************************
    // address formation and output register
    // ************************************************************

    chan_addr_t mapped;

    chan_addr_mux u_mux (
        .x_coord   (x_coord),
        .y_coord   (y_coord),
        .src_codes (src_codes),
        .addr      (mapped)
    );

    chan_addr_t next_chan_addr;
    logic       next_chan_valid;
    logic       next_map_error;

    // hold last address; bad mapping never marks a sample valid
    always_comb begin
        next_chan_addr  = chan_addr;
        next_chan_valid = 1'b0;
        next_map_error  = cfg_taken && cfg_bad;
        if (coord_valid && cfg_taken && !cfg_bad) begin
            next_chan_addr  = mapped;
            next_chan_valid = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chan_addr  <= '0;
            chan_valid <= 1'b0;
            map_error  <= 1'b0;
        end else begin
            chan_addr  <= next_chan_addr;
            chan_valid <= next_chan_valid;
            map_error  <= next_map_error;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************

    property p_default_map;
        @(posedge clock) disable iff (!rst_sync_n)
        (coord_valid && cfg_taken && !cfg_bad && cfg_preset == `PRESET_DEFAULT)
        |=> chan_addr == {$past(x_coord[7:4]), $past(y_coord[7:0])};
    endproperty
    a_default_map: assert property (p_default_map) else $error("default map wrong");

    property p_x_only_map;
        @(posedge clock) disable iff (!rst_sync_n)
        (coord_valid && cfg_taken && !cfg_bad && cfg_preset == `PRESET_X_ONLY)
        |=> chan_addr == {5'h00, $past(x_coord[7:1])};
    endproperty
    a_x_only_map: assert property (p_x_only_map) else $error("x-only map wrong");

    property p_square_map;
        @(posedge clock) disable iff (!rst_sync_n)
        (coord_valid && cfg_taken && !cfg_bad && cfg_preset == `PRESET_SQUARE)
        |=> chan_addr == {$past(x_coord[7:2]), $past(y_coord[7:2])};
    endproperty
    a_square_map: assert property (p_square_map) else $error("square map wrong");

    property p_high_zero;
        @(posedge clock) disable iff (!rst_sync_n)
        (coord_valid && cfg_taken && !cfg_bad)
        |=> (chan_addr >> $past({1'b0, x_cnt} + {1'b0, y_cnt})) == '0;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("unused high bits not zero");

    property p_count_limit;
        @(posedge clock) disable iff (!rst_sync_n)
        chan_valid |-> $past({1'b0, x_cnt} + {1'b0, y_cnt}) <= 5'(`ADDR_W);
    endproperty
    a_count_limit: assert property (p_count_limit) else $error("too many bits mapped");

    property p_y_only;
        @(posedge clock) disable iff (!rst_sync_n)
        (cfg_taken && cfg_y_only && x_cnt != `NONE_CNT) |=> map_error && !chan_valid;
    endproperty
    a_y_only: assert property (p_y_only) else $error("x used with y-only source");

    property p_static_cfg;
        @(posedge clock) disable iff (!rst_sync_n)
        $past(cfg_taken) |-> $stable(src_codes);
    endproperty
    a_static_cfg: assert property (p_static_cfg) else $error("mapping changed");

    sequence s_sample;
        coord_valid && cfg_taken && !cfg_bad;
    endsequence

    property p_valid_one;
        @(posedge clock) disable iff (!rst_sync_n)
        s_sample |=> chan_valid ##1 (chan_valid == $past(coord_valid && cfg_taken && !cfg_bad));
    endproperty
    a_valid_one: assert property (p_valid_one) else $error("valid timing wrong");

endmodule // chan_map

`default_nettype wire

// ==== tb/position_source.sv ====
// behavioural position computer that offers x and y coordinate words
// assumes: bench sets send and the words by non-blocking assignment at the clock edge
`timescale 1ns/100ps
`default_nettype none

module position_source
    import chan_map_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   send,
    input  wire logic   no_x,
    input  wire coord_t x_word,
    input  wire coord_t y_word,
    output coord_t      x_coord,
    output coord_t      y_coord,
    output logic        coord_valid
);
    // ************************************************************
    // idle lines
    // ************************************************************
    coord_t junk_x = 10'h155;
    coord_t junk_y = 10'h2AA;

    // outside a sample the lines toggle, so a stale word never looks valid
    always @(posedge clock) begin
        junk_x <= send ? ~x_word : ~junk_x;
        junk_y <= send ? ~y_word : ~junk_y;
    end

    // a y-only source has no x data at all, its x lines carry noise
    assign x_coord     = (send && !no_x) ? x_word : junk_x;
    assign y_coord     = send ? y_word : junk_y;
    assign coord_valid = send;
endmodule // position_source
`default_nettype wire

// ==== tb/test_chan_map.sv ====
// self-checking bench for the coordinate to channel address mapper
// assumes: design files and package compiled first, header on the include path
`timescale 1ns/100ps
`default_nettype none
`include "chan_map_regs.svh"

module test_chan_map
    import chan_map_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    typedef struct {int pre, lx, xc, yc, xm, ym, yo, bad;} cfg_s;

    logic       clock;
    logic       resetn;
    logic       send;
    logic       no_x;
    logic       custom_low_x;
    logic       coord_valid;
    logic       chan_valid;
    logic       map_error;
    logic       valid_q;
    coord_t     x_word;
    coord_t     y_word;
    coord_t     x_coord;
    coord_t     y_coord;
    preset_t    preset_sel;
    bit_idx_t   custom_x_cnt;
    bit_idx_t   custom_y_cnt;
    bit_idx_t   x_res_msb;
    bit_idx_t   y_res_msb;
    chan_addr_t chan_addr;
    chan_addr_t exp_addr;
    logic [31:0] seed;
    int         fails;
    int         comparisons;
    coord_t     corner [4] = '{10'h3FF, 10'h000, 10'h2AA, 10'h155};
    // pre, low_x, x count, y count, x msb, y msb, y-only, illegal
    cfg_s       cfgs [10] = '{
        '{0, 0, 4, 8, 7, 7, 0, 0},
        '{1, 1, 7, 0, 7, 7, 0, 0},
        '{2, 0, 6, 6, 7, 7, 0, 0},
        '{3, 1, 4, 6, 9, 9, 0, 0},
        '{3, 0, 6, 6, 9, 7, 0, 0},
        '{3, 0, 0, 10, 9, 9, 1, 0},
        '{3, 0, 7, 6, 9, 9, 0, 1},
        '{0, 0, 4, 8, 7, 7, 1, 1},
        '{3, 0, 5, 3, 3, 7, 0, 1},
        '{3, 1, 2, 1, 9, 9, 0, 0}
    };

    // ************************************************************
    // design and partner
    // ************************************************************
    chan_map dut (
        .clock        (clock),
        .resetn       (resetn),
        .x_coord      (x_coord),
        .y_coord      (y_coord),
        .coord_valid  (coord_valid),
        .preset_sel   (preset_sel),
        .custom_low_x (custom_low_x),
        .custom_x_cnt (custom_x_cnt),
        .custom_y_cnt (custom_y_cnt),
        .x_res_msb    (x_res_msb),
        .y_res_msb    (y_res_msb),
        .y_only_source(no_x),
        .chan_addr    (chan_addr),
        .chan_valid   (chan_valid),
        .map_error    (map_error)
    );

    position_source src (
        .clock      (clock),
        .send       (send),
        .no_x       (no_x),
        .x_word     (x_word),
        .y_word     (y_word),
        .x_coord    (x_coord),
        .y_coord    (y_coord),
        .coord_valid(coord_valid)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    // free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // top count bits of each axis, low axis from bit 0, the other right above
    function automatic chan_addr_t map_exp(input cfg_s c, input coord_t x, input coord_t y);
        logic [11:0] xb;
        logic [11:0] yb;
        xb = 12'((x >> (c.xm - c.xc + 1)) & ((1 << c.xc) - 1));
        yb = 12'((y >> (c.ym - c.yc + 1)) & ((1 << c.yc) - 1));
        return c.lx ? 12'(xb | (yb << c.xc)) : 12'(yb | (xb << c.yc));
    endfunction

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // straps only take effect through a reset, so each mapping gets its own
    task automatic run_cfg(input cfg_s c);
        logic v;
        coord_t x;
        coord_t y;
        // reset and straps change on an edge, like every other input
        @(posedge clock);
        resetn       <= 1'b0;
        send         <= 1'b0;
        preset_sel   <= 2'(c.pre);
        custom_low_x <= 1'(c.lx);
        custom_x_cnt <= 4'(c.xc);
        custom_y_cnt <= 4'(c.yc);
        x_res_msb    <= 4'(c.xm);
        y_res_msb    <= 4'(c.ym);
        no_x         <= 1'(c.yo);
        repeat (4) @(posedge clock);
        #1;
        check("reset chan_addr", 12'h000, chan_addr);
        check("reset chan_valid", 12'h000, {11'h000, chan_valid});
        @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check("map_error", 12'(c.bad), {11'h000, map_error});
        exp_addr = 12'h000;
        valid_q  = 1'b0;
        for (int i = 0; i < 60; i++) begin
            @(posedge clock);
            seed = xs(seed);
            v = (i < 8) || seed[0];
            x = (i < 4) ? corner[i] : seed[10:1];
            y = (i < 4) ? corner[i ^ 1] : seed[20:11];
            send         <= v;
            x_word       <= x;
            y_word       <= y;
            preset_sel   <= seed[22:21];
            custom_low_x <= seed[23];
            custom_x_cnt <= seed[27:24];
            custom_y_cnt <= seed[31:28];
            x_res_msb    <= seed[25:22];
            y_res_msb    <= seed[29:26];
            #1;
            check("chan_valid", {11'h000, valid_q}, {11'h000, chan_valid});
            check("chan_addr", exp_addr, chan_addr);
            check("map_error", 12'(c.bad), {11'h000, map_error});
            if (v && c.bad == 0) begin
                exp_addr = map_exp(c, x, y);
            end
            valid_q = v && c.bad == 0;
        end
        // the last sample of the loop still has to be looked at
        @(posedge clock);
        send <= 1'b0;
        #1;
        check("last chan_valid", {11'h000, valid_q}, {11'h000, chan_valid});
        check("last chan_addr", exp_addr, chan_addr);
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    // main run: every mapping with corner words first, then random traffic
    initial begin
        resetn       = 1'b0;
        send         = 1'b0;
        no_x         = 1'b0;
        x_word       = 10'h000;
        y_word       = 10'h000;
        preset_sel   = 2'h0;
        custom_low_x = 1'b0;
        custom_x_cnt = 4'h0;
        custom_y_cnt = 4'h0;
        x_res_msb    = 4'h7;
        y_res_msb    = 4'h7;
        seed         = 32'h0000FAD9;
        fails        = 0;
        comparisons  = 0;
        foreach (cfgs[k]) begin
            run_cfg(cfgs[k]);
        end
        end_sim();
    end

    // watchdog: the run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        end_sim();
    end
endmodule // test_chan_map
`default_nettype wire
